// ---- core_status_option_irq_regs_test.sv ----
// Purpose: self-checking bench for the core register bank
// Assumes: lfsr stimulus from a fixed seed
// Notes: only mismatches and the verdict are printed
`timescale 1ns/1ps
`default_nettype none
`include "csr_params.svh"
module core_status_option_irq_regs_test
  import csr_pkg::*;
;
  logic       clk, rst_b, ce, wr_en, rd_en, pin, pbr, rd_hit, bank_i;
  logic       xclk, fall, to_wdt, edge_r, irq;
  logic [8:0] addr;
  logic [7:0] wr_data, a, b, res, rd_data, latch, pflags, pu, q, v, st;
  logic [3:0] ev, nib, trate;
  logic [2:0] wrate;
  logic [1:0] bank_d;
  logic [31:0] seed;
  csr_alu_e   op;
  int         bad_count, checked;
  csr_cpu_model cpu (.i_clk(clk), .i_rd_data(rd_data), .o_ce(ce), .o_addr(addr),
    .o_wr_en(wr_en), .o_wr_data(wr_data), .o_rd_en(rd_en), .o_alu_op(op),
    .o_a(a), .o_b(b), .o_res(res), .o_ev(ev));
  csr_core_regs dut (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_addr(addr),
    .i_wr_en(wr_en), .i_wr_data(wr_data), .i_rd_en(rd_en), .o_rd_data(rd_data),
    .o_rd_hit(rd_hit), .i_alu_op(op), .i_alu_a(a), .i_alu_b(b),
    .i_alu_result(res), .i_watchdog_clear_instruction(ev[0]), .i_sleep(ev[1]), .i_wdt_timeout(ev[2]),
    .i_eight_bit_timer_counter_overflow(ev[3]), .i_ext_irq_pin(pin), .i_port_upper_nibble_pins(nib),
    .i_port_b_read(pbr), .i_port_b_latch(latch), .i_peripheral_flags(pflags),
    .o_bank_direct(bank_d), .o_bank_indirect(bank_i), .o_pullup_en(pu),
    .o_timer_ext_clk(xclk), .o_timer_fall_edge(fall), .o_prescaler_to_wdt(to_wdt),
    .o_timer_rate_log2(trate), .o_wdt_rate_log2(wrate), .o_ext_edge_rising(edge_r),
    .o_irq(irq));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] nx(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] flg(csr_alu_e o, logic [7:0] x, logic [7:0] y,
                                     logic [7:0] s);
    logic [8:0] t;
    logic [4:0] h;
    t = (o == CSR_ALU_SUB) ? {1'b0, x} + {1'b0, ~y} + 9'h001 : {1'b0, x} + {1'b0, y};
    h = (o == CSR_ALU_SUB) ? {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + 5'h01
                           : {1'b0, x[3:0]} + {1'b0, y[3:0]};
    case (o)
      CSR_ALU_ADD, CSR_ALU_SUB: s[2:0] = {t[7:0] == 8'h00, h[4], t[8]};
      CSR_ALU_LOGIC: s[2] = (x ^ y) == 8'h00;
      CSR_ALU_RLF: s[0] = x[7];
      CSR_ALU_RRF: s[0] = x[0];
      default: ;
    endcase
    return s;
  endfunction
  task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [8:0] ad, output logic [7:0] d);
    cpu.acc(1'b0, 1'b1, ad, 8'h00, CSR_ALU_NONE, 8'h00, 8'h00, d);
  endtask
  task automatic wr(input logic [8:0] ad, input logic [7:0] d);
    logic [7:0] x;
    cpu.acc(1'b1, 1'b0, ad, d, CSR_ALU_NONE, 8'h00, 8'h00, x);
  endtask
  task automatic pin_step(input logic p, input logic [7:0] e);
    logic [7:0] x;
    pin = p;
    repeat (6) @(posedge clk);
    rd(9'h00B, x);
    chk("interrupt_control_reg_pin", x, e);
    wr(9'h00B, 8'h00);
  endtask
  task automatic test_done;
    if (bad_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    bad_count++;
    test_done();
  end
  initial
  begin
    {rst_b, pin, pbr, nib, pflags, bad_count, checked} = '0;
    latch = 8'hA5;
    seed = 32'h29fdf65d;
    repeat (6) @(posedge clk);
    #1 rst_b = 1'b1;
    chk("pullup_rst", pu, 8'h00);
    chk("rates_rst", {1'b0, wrate, trate}, 8'h70);
    rd(9'h003, q);
    chk("status_rst", q, `CSR_STATUS_RST);
    rd(9'h08B, q);
    chk("interrupt_control_reg_rst", q, `CSR_INTERRUPT_CONTROL_REG_RST);
    rd(9'h081, q);
    chk("option_rst", q, `CSR_OPTION_RST);
    rd(9'h08C, q);
    chk("pie_rst", {q[6:0], rd_hit}, {`CSR_PIE_RST, 1'b1});
    wr(9'h003, 8'h00);
    rd(9'h183, q);
    chk("status_ro", q, 8'h18);
    wr(9'h083, 8'h27); // upper select bits kept clear
    rd(9'h103, q);
    chk("status_wr", q, 8'h3F);
    chk("bank", {5'h00, bank_i, bank_d}, 8'h01);
    st = 8'h3F;
    for (int i = 0; i < 24; i++)
    begin
      seed = nx(seed);
      cpu.acc(1'b0, 1'b0, 9'h000, 8'h00, csr_alu_e'(3'd1 + 3'(seed[2:0] % 5)),
              seed[15:8], (i == 0) ? seed[15:8] : seed[23:16], q);
      st = flg(csr_alu_e'(3'd1 + 3'(seed[2:0] % 5)), seed[15:8],
               (i == 0) ? seed[15:8] : seed[23:16], st);
      rd({seed[25:24], 7'h03}, q);
      chk("alu_flags", q, st);
    end
    cpu.acc(1'b1, 1'b0, 9'h003, 8'h07, CSR_ALU_ADD, 8'h00, 8'h00, q);
    rd(9'h003, q);
    chk("status_flag_wr", q, 8'h1C);
    cpu.acc(1'b1, 1'b0, 9'h003, 8'h03, CSR_ALU_LOGIC, 8'h0F, 8'h0F, q);
    rd(9'h003, q);
    chk("status_logic_wr", q, 8'h1C);
    for (int k = 1; k >= 0; k--)
    begin
      cpu.ev(k + 1);
      rd(9'h003, q);
      chk("sleep_tmo", {6'h00, q[4:3]}, {6'h00, k == 0, k == 1});
    end
    cpu.ev(0);
    rd(9'h003, q);
    chk("watchdog_clear_instruction", {6'h00, q[4:3]}, 8'h03);
    for (int i = 0; i < 8; i++)
    begin
      seed = nx(seed);
      v = (i == 0) ? 8'h07 : seed[7:0];
      latch = seed[15:8];
      wr(9'h081, v);
      rd(9'h081, q);
      chk("option", q, v);
      chk("pullup", pu, v[7] ? 8'h00 : latch);
      chk("opt_bits", {4'h0, edge_r, xclk, fall, to_wdt}, {4'h0, v[6:3]});
      chk("rates", {1'b0, wrate, trate},
          v[3] ? {1'b0, v[2:0], 4'h0} : {4'h0, 4'(v[2:0]) + 4'h1});
    end
    rd(9'h105, q);
    chk("unmapped", {q[6:0], rd_hit}, 8'h00);
    wr(9'h181, ~v);
    rd(9'h081, q);
    chk("opt_alias", q, v);
    wr(9'h081, 8'h40);
    wr(9'h00B, 8'h00); // flags cleared before enabling
    cpu.hold(1'b0);
    cpu.ev(3);
    cpu.hold(1'b1);
    rd(9'h00B, q);
    chk("ce_freeze", q, 8'h00);
    cpu.ev(3);
    rd(9'h00B, q);
    chk("tmr_flag", {q[6:0], irq}, 8'h08);
    wr(9'h00B, 8'hA4);
    chk("irq_on", {7'h00, irq}, 8'h01);
    wr(9'h00B, 8'h24);
    chk("irq_gie", {7'h00, irq}, 8'h00);
    wr(9'h00B, 8'hC0);
    for (int k = 0; k < 8; k++)
    begin
      wr(9'h08C, 8'h01 << k);
      pflags = ~(8'h01 << k);
      @(posedge clk);
      #1 chk("pirq_off", {7'h00, irq}, 8'h00);
      pflags = 8'h01 << k;
      @(posedge clk);
      #1 chk("pirq_on", {7'h00, irq}, 8'h01);
    end
    wr(9'h00B, 8'h80);
    chk("peripheral_irq_gate_gate", {7'h00, irq}, 8'h00);
    wr(9'h00B, 8'h00);
    pflags = 8'h00;
    pin_step(1'b1, 8'h02);
    pin_step(1'b0, 8'h00);
    wr(9'h081, 8'h00);
    pin_step(1'b1, 8'h00);
    pin_step(1'b0, 8'h02);
    nib = 4'h9;
    repeat (5) @(posedge clk);
    wr(9'h00B, 8'h00);
    rd(9'h00B, q);
    chk("pc_hold", q, 8'h01);
    @(posedge clk);
    #1 pbr = 1'b1;
    @(posedge clk);
    #1 pbr = 1'b0;
    wr(9'h00B, 8'h00);
    rd(9'h00B, q);
    chk("pc_clear", q, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire

// ---- csr_core_regs.sv ----
// Purpose: status, option, interrupt control and peripheral enable registers
// Assumes: core accesses on i_clk, one access per enabled cycle
// Notes: read data is registered one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "csr_params.svh"

module csr_core_regs
  import csr_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_ce,
  input  wire logic [8:0] i_addr,
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_rd_en,
  output logic      [7:0] o_rd_data,
  output logic            o_rd_hit,
  input  wire csr_alu_e   i_alu_op,
  input  wire logic [7:0] i_alu_a,
  input  wire logic [7:0] i_alu_b,
  input  wire logic [7:0] i_alu_result,
  input  wire logic       i_watchdog_clear_instruction,
  input  wire logic       i_sleep,
  input  wire logic       i_wdt_timeout,
  input  wire logic       i_eight_bit_timer_counter_overflow,
  input  wire logic       i_ext_irq_pin,
  input  wire logic [3:0] i_port_upper_nibble_pins,
  input  wire logic       i_port_b_read,
  input  wire logic [7:0] i_port_b_latch,
  input  wire logic [7:0] i_peripheral_flags,
  output logic      [1:0] o_bank_direct,
  output logic            o_bank_indirect,
  output logic      [7:0] o_pullup_en,
  output logic            o_timer_ext_clk,
  output logic            o_timer_fall_edge,
  output logic            o_prescaler_to_wdt,
  output logic      [3:0] o_timer_rate_log2,
  output logic      [2:0] o_wdt_rate_log2,
  output logic            o_ext_edge_rising,
  output logic            o_irq
);

  function automatic csr_sel_e csr_decode(input logic [8:0] addr);
    csr_sel_e sel;
    sel = CSR_SEL_NONE;
    if (addr[6:0] == `CSR_STATUS_OFS)
      sel = CSR_SEL_STATUS;
    else if (addr[6:0] == `CSR_INTERRUPT_CONTROL_REG_OFS)
      sel = CSR_SEL_INTERRUPT_CONTROL_REG;
    else if (addr == `CSR_OPTION_ADDR)
      sel = CSR_SEL_OPTION;
    else if (addr == `CSR_PIE_ADDR)
      sel = CSR_SEL_PIE;
    return sel;
  endfunction

  csr_state_s state_reg;
  csr_state_s state_next;

  logic [8:0] sum9;
  logic [4:0] sum5;
  logic       pin_edge;
  logic       pb_mismatch;
  logic       core_pend;
  logic       periph_pend;
  csr_sel_e   wr_sel;
  csr_sel_e   rd_sel;

  // adder: subtraction adds the two's complement of b
  always_comb
  begin
    sum9 = 9'h000;
    sum5 = 5'h00;
    if (i_alu_op == CSR_ALU_SUB)
    begin
      sum9 = {1'b0, i_alu_a} + {1'b0, ~i_alu_b} + 9'h001;
      sum5 = {1'b0, i_alu_a[3:0]} + {1'b0, ~i_alu_b[3:0]} + 5'h01;
    end
    else
    begin
      sum9 = {1'b0, i_alu_a} + {1'b0, i_alu_b};
      sum5 = {1'b0, i_alu_a[3:0]} + {1'b0, i_alu_b[3:0]};
    end
  end

  assign wr_sel = i_wr_en ? csr_decode(i_addr) : CSR_SEL_NONE;
  assign rd_sel = i_rd_en ? csr_decode(i_addr) : CSR_SEL_NONE;

  // edge of the synchronised external pin
  assign pin_edge = state_reg.option[`CSR_OP_EDGE]
                    ? (state_reg.ext_s2 & ~state_reg.ext_prev)
                    : (~state_reg.ext_s2 & state_reg.ext_prev);
  assign pb_mismatch = |(state_reg.pb_s2 ^ state_reg.pb_snap);

  always_comb
  begin
    state_next = state_reg;
    if (i_ce)
    begin
      state_next.ext_s1   = i_ext_irq_pin;
      state_next.ext_s2   = state_reg.ext_s1;
      state_next.ext_prev = state_reg.ext_s2;
      state_next.pb_s1    = i_port_upper_nibble_pins;
      state_next.pb_s2    = state_reg.pb_s1;
      if (i_port_b_read)
        state_next.pb_snap = state_reg.pb_s2;

      case (wr_sel)
        CSR_SEL_STATUS:
        begin
          state_next.status[`CSR_ST_IRP:`CSR_ST_RP_LO] = i_wr_data[`CSR_ST_IRP:`CSR_ST_RP_LO];
          if (i_alu_op == CSR_ALU_NONE)
            state_next.status[`CSR_ST_Z:`CSR_ST_C] = i_wr_data[`CSR_ST_Z:`CSR_ST_C];
        end
        CSR_SEL_INTERRUPT_CONTROL_REG:
          state_next.interrupt_control_reg = i_wr_data;
        CSR_SEL_OPTION:
          state_next.option = i_wr_data;
        CSR_SEL_PIE:
          state_next.pie = i_wr_data;
        default:
          state_next.interrupt_control_reg = state_reg.interrupt_control_reg;
      endcase

      // flag update from the instruction result
      case (i_alu_op)
        CSR_ALU_ADD, CSR_ALU_SUB:
        begin
          state_next.status[`CSR_ST_Z]  = (sum9[7:0] == 8'h00);
          state_next.status[`CSR_ST_DC] = sum5[4];
          state_next.status[`CSR_ST_C]  = sum9[8];
        end
        CSR_ALU_LOGIC:
          state_next.status[`CSR_ST_Z] = (i_alu_result == 8'h00);
        CSR_ALU_RLF:
          state_next.status[`CSR_ST_C] = i_alu_a[7];
        CSR_ALU_RRF:
          state_next.status[`CSR_ST_C] = i_alu_a[0];
        default:
          state_next.status[`CSR_ST_C] = state_next.status[`CSR_ST_C];
      endcase

      // expiry and power-down flags follow events only
      if (i_watchdog_clear_instruction)
      begin
        state_next.status[`CSR_ST_TO] = 1'b1;
        state_next.status[`CSR_ST_PD] = 1'b1;
      end
      if (i_sleep)
      begin
        state_next.status[`CSR_ST_TO] = 1'b1;
        state_next.status[`CSR_ST_PD] = 1'b0;
      end
      if (i_wdt_timeout)
        state_next.status[`CSR_ST_TO] = 1'b0;

      // hardware sets win over a software clear
      if (i_eight_bit_timer_counter_overflow)
        state_next.interrupt_control_reg[`CSR_IC_TIF] = 1'b1;
      if (pin_edge)
        state_next.interrupt_control_reg[`CSR_IC_XIF] = 1'b1;
      if (pb_mismatch)
        state_next.interrupt_control_reg[`CSR_IC_PCIF] = 1'b1;

      state_next.rd_hit = (rd_sel != CSR_SEL_NONE);
      case (rd_sel)
        CSR_SEL_STATUS:
          state_next.rd_data = state_reg.status;
        CSR_SEL_INTERRUPT_CONTROL_REG:
          state_next.rd_data = state_reg.interrupt_control_reg;
        CSR_SEL_OPTION:
          state_next.rd_data = state_reg.option;
        CSR_SEL_PIE:
          state_next.rd_data = state_reg.pie;
        default:
          state_next.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_reg          <= '0;
      state_reg.status   <= `CSR_STATUS_RST;
      state_reg.interrupt_control_reg   <= `CSR_INTERRUPT_CONTROL_REG_RST;
      state_reg.option   <= `CSR_OPTION_RST;
      state_reg.pie      <= `CSR_PIE_RST;
    end
    else
      state_reg <= state_next;
  end

  assign o_rd_data         = state_reg.rd_data;
  assign o_rd_hit          = state_reg.rd_hit;
  assign o_bank_direct     = state_reg.status[`CSR_ST_RP_HI:`CSR_ST_RP_LO];
  assign o_bank_indirect   = state_reg.status[`CSR_ST_IRP];
  assign o_pullup_en       = state_reg.option[`CSR_OP_PUD] ? 8'h00 : i_port_b_latch;
  assign o_timer_ext_clk   = state_reg.option[`CSR_OP_CS];
  assign o_timer_fall_edge = state_reg.option[`CSR_OP_SE];
  assign o_prescaler_to_wdt = state_reg.option[`CSR_OP_PSA];
  assign o_ext_edge_rising = state_reg.option[`CSR_OP_EDGE];
  // timer divides by 2^(rate+1) unless the prescaler is with the watchdog
  assign o_timer_rate_log2 = state_reg.option[`CSR_OP_PSA] ? 4'h0
                           : {1'b0, state_reg.option[`CSR_OP_PS_HI:`CSR_OP_PS_LO]}
                             + `CSR_RATE_ONE;
  assign o_wdt_rate_log2   = state_reg.option[`CSR_OP_PSA]
                           ? state_reg.option[`CSR_OP_PS_HI:`CSR_OP_PS_LO] : 3'h0;

  assign core_pend = (state_reg.interrupt_control_reg[`CSR_IC_TIF] & state_reg.interrupt_control_reg[`CSR_IC_TIE])
                   | (state_reg.interrupt_control_reg[`CSR_IC_XIF] & state_reg.interrupt_control_reg[`CSR_IC_XIE])
                   | (state_reg.interrupt_control_reg[`CSR_IC_PCIF] & state_reg.interrupt_control_reg[`CSR_IC_PCIE]);
  assign periph_pend = state_reg.interrupt_control_reg[`CSR_IC_PERIPHERAL_IRQ_GATE]
                     & (|(i_peripheral_flags & state_reg.pie));
  assign o_irq = state_reg.interrupt_control_reg[`CSR_IC_GIE] & (core_pend | periph_pend);

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_pin_rise;
    i_ce && state_reg.option[`CSR_OP_EDGE] && state_reg.ext_s2 && !state_reg.ext_prev;
  endsequence

  sequence s_sleep_only;
    i_ce && i_sleep && !i_watchdog_clear_instruction && !i_wdt_timeout;
  endsequence

  sequence s_status_wr_masked;
    i_ce && wr_sel == CSR_SEL_STATUS && i_alu_op == CSR_ALU_LOGIC;
  endsequence

  flag_write_mask_a: assert property (s_status_wr_masked |=>
    state_reg.status[`CSR_ST_Z] == ($past(i_alu_result) == 8'h00)
    && state_reg.status[`CSR_ST_C] == $past(state_reg.status[`CSR_ST_C]))
    else $error("status flag write not masked");

  ro_flags_a: assert property (i_ce && !i_watchdog_clear_instruction && !i_sleep && !i_wdt_timeout |=>
    $stable(state_reg.status[`CSR_ST_TO:`CSR_ST_PD]))
    else $error("read-only flags changed");

  bank_out_a: assert property (i_ce && wr_sel == CSR_SEL_STATUS |=>
    o_bank_direct == $past(i_wr_data[`CSR_ST_RP_HI:`CSR_ST_RP_LO]))
    else $error("bank select mismatch");

  sleep_flags_a: assert property (s_sleep_only |=>
    !state_reg.status[`CSR_ST_PD] && state_reg.status[`CSR_ST_TO] ##1 1)
    else $error("sleep did not set expiry and clear power-down");

  timeout_a: assert property (i_ce && i_wdt_timeout |=> !state_reg.status[`CSR_ST_TO])
    else $error("timeout did not clear expiry flag");

  add_carry_a: assert property (i_ce && i_alu_op == CSR_ALU_ADD |=>
    state_reg.status[`CSR_ST_C] == (({1'b0, $past(i_alu_a)} + {1'b0, $past(i_alu_b)}) > 9'h0FF))
    else $error("add carry wrong");

  rot_carry_a: assert property (i_ce && i_alu_op == CSR_ALU_RRF |=>
    state_reg.status[`CSR_ST_C] == $past(i_alu_a[0]))
    else $error("rotate carry wrong");

  pullup_off_a: assert property (state_reg.option[`CSR_OP_PUD] |-> o_pullup_en == 8'h00)
    else $error("pull-ups on while disabled");

  ext_flag_a: assert property (s_pin_rise |=> state_reg.interrupt_control_reg[`CSR_IC_XIF] [*2])
    else $error("external flag not set and held");

  global_gate_a: assert property (!state_reg.interrupt_control_reg[`CSR_IC_GIE] |-> !o_irq)
    else $error("request while globally disabled");

  periph_gate_a: assert property (!state_reg.interrupt_control_reg[`CSR_IC_PERIPHERAL_IRQ_GATE] && !core_pend |-> !o_irq)
    else $error("peripheral request while gated");

  port_change_a: assert property (i_ce && pb_mismatch |=> state_reg.interrupt_control_reg[`CSR_IC_PCIF])
    else $error("port change flag not set");

  timer_rate_a: assert property (!state_reg.option[`CSR_OP_PSA] |->
    o_timer_rate_log2 != 4'h0 && o_wdt_rate_log2 == 3'h0)
    else $error("prescaler rate wrong");

endmodule
`default_nettype wire

// ---- csr_cpu_model.sv ----
// Purpose: core-side access model driving the register bank
// Assumes: each acc call is one access; every task drives 1 ns after the edge
// Notes: after an access the strobes and operation drop to idle; address, data and operand lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module csr_cpu_model
  import csr_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rd_data,
  output logic            o_ce,
  output logic      [8:0] o_addr,
  output logic            o_wr_en,
  output logic      [7:0] o_wr_data,
  output logic            o_rd_en,
  output csr_alu_e        o_alu_op,
  output logic      [7:0] o_a,
  output logic      [7:0] o_b,
  output logic      [7:0] o_res,
  output logic      [3:0] o_ev
);
  initial
  begin
    o_ce = 1'b1;
    {o_addr, o_wr_en, o_wr_data, o_rd_en, o_a, o_b, o_ev} = '0;
    o_alu_op = CSR_ALU_NONE;
  end
  assign o_res = o_a ^ o_b;
  // one core cycle: optional write, read and flag-affecting operation
  task automatic acc(input logic w, input logic r, input logic [8:0] ad,
                     input logic [7:0] d, input csr_alu_e op,
                     input logic [7:0] a, input logic [7:0] b,
                     output logic [7:0] q);
    @(posedge i_clk);
    #1;
    {o_wr_en, o_rd_en, o_addr, o_wr_data} = {w, r, ad, d};
    {o_alu_op, o_a, o_b} = {op, a, b};
    @(posedge i_clk);
    #1;
    q = i_rd_data;
    {o_wr_en, o_rd_en, o_alu_op} = {1'b0, 1'b0, CSR_ALU_NONE};
    {o_addr, o_wr_data, o_a, o_b} = ~{o_addr, o_wr_data, o_a, o_b};
  endtask
  // clock enable level from the next cycle on
  task automatic hold(input logic c);
    @(posedge i_clk);
    #1;
    o_ce = c;
  endtask
  // single-cycle event: 0 clear, 1 sleep, 2 time-out, 3 timer overflow
  task automatic ev(input int k);
    @(posedge i_clk);
    #1;
    o_ev = 4'h1 << k;
    @(posedge i_clk);
    #1;
    o_ev = 4'h0;
  endtask
endmodule
`default_nettype wire

// ---- csr_params.svh ----
// Purpose: constants for the core status, option and interrupt register bank
// Assumes: 9-bit data file address, 8-bit registers
// Notes: included by the test bench and the register bank
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH

`define CSR_STATUS_OFS   7'h03
`define CSR_INTERRUPT_CONTROL_REG_OFS   7'h0B
`define CSR_OPTION_ADDR  9'h081
`define CSR_PIE_ADDR     9'h08C

`define CSR_STATUS_RST   8'h18
`define CSR_INTERRUPT_CONTROL_REG_RST   8'h00
`define CSR_OPTION_RST   8'hFF
`define CSR_PIE_RST      8'h00

`define CSR_ST_IRP       7
`define CSR_ST_RP_HI     6
`define CSR_ST_RP_LO     5
`define CSR_ST_TO        4
`define CSR_ST_PD        3
`define CSR_ST_Z         2
`define CSR_ST_DC        1
`define CSR_ST_C         0

`define CSR_OP_PUD       7
`define CSR_OP_EDGE      6
`define CSR_OP_CS        5
`define CSR_OP_SE        4
`define CSR_OP_PSA       3
`define CSR_OP_PS_HI     2
`define CSR_OP_PS_LO     0

`define CSR_IC_GIE       7
`define CSR_IC_PERIPHERAL_IRQ_GATE      6
`define CSR_IC_TIE       5
`define CSR_IC_XIE       4
`define CSR_IC_PCIE      3
`define CSR_IC_TIF       2
`define CSR_IC_XIF       1
`define CSR_IC_PCIF      0

`define CSR_NIB_MSB      3
`define CSR_RATE_ONE     4'h1
`endif

// ---- csr_pkg.sv ----
// Purpose: types shared by the core register bank
// Assumes: csr_params.svh holds every number
// Notes: none
package csr_pkg;

  typedef enum logic [2:0] {
    CSR_ALU_NONE,
    CSR_ALU_ADD,
    CSR_ALU_SUB,
    CSR_ALU_LOGIC,
    CSR_ALU_RLF,
    CSR_ALU_RRF
  } csr_alu_e;

  typedef enum logic [2:0] {
    CSR_SEL_NONE,
    CSR_SEL_STATUS,
    CSR_SEL_INTERRUPT_CONTROL_REG,
    CSR_SEL_OPTION,
    CSR_SEL_PIE
  } csr_sel_e;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] interrupt_control_reg;
    logic [7:0] option;
    logic [7:0] pie;
    logic [7:0] rd_data;
    logic       rd_hit;
    logic       ext_s1;
    logic       ext_s2;
    logic       ext_prev;
    logic [3:0] pb_s1;
    logic [3:0] pb_s2;
    logic [3:0] pb_snap;
  } csr_state_s;

endpackage
